// ==== mbs_pkg.sv ====
package mbs_pkg;

    // ****************************************************************
    // clock and bit timing
    // ****************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int OVS = 8;
    localparam int OVS_HALF = OVS / 2;
    localparam int DIV_W = 11;
    localparam int GAP_HALF_CHARS = 7;
    localparam int IDLE_W = 10;
    localparam int BIT_US_RST = 26;

    localparam int BAUD_1200 = 1200;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115200 = 115200;

    typedef logic [DIV_W-1:0] mbs_div_t;

    // ****************************************************************
    // configuration codes and reset values
    // ****************************************************************
    localparam logic [2:0] BAUD_SEL_2400 = 3'h1;
    localparam logic [2:0] BAUD_SEL_RST = 3'h5;
    localparam logic [7:0] NODE_ADDR_RST = 8'h01;
    localparam logic [7:0] P2P_NODE_ADDR = 8'h01;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [3:0] CHAR_BITS_BASE = 4'hA;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_ODD = 2'h2
    } mbs_par_e;

    // oversample divisor, rounded to nearest
    function automatic mbs_div_t baud_div(input logic [2:0] sel);
        int b;
        case (sel)
            3'h0: b = BAUD_1200;
            3'h1: b = BAUD_2400;
            3'h2: b = BAUD_4800;
            3'h3: b = BAUD_9600;
            3'h4: b = BAUD_19200;
            3'h5: b = BAUD_38400;
            3'h6: b = BAUD_57600;
            default: b = BAUD_115200;
        endcase
        return DIV_W'((CLK_HZ + b * OVS / 2) / (b * OVS));
    endfunction

    // ****************************************************************
    // state codes and state records
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PAR = 5'h08,
        ST_STOP = 5'h10
    } mbs_st_e;

    typedef struct packed {
        mbs_div_t div_cnt;
        logic tick;
        mbs_st_e st_rx;
        logic [2:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_perr;
        logic rx_ferr;
        logic rx_first;
        logic gap_seen;
        logic [IDLE_W-1:0] idle_cnt;
        mbs_st_e st_tx;
        logic [2:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic txd;
        logic de;
        logic tx_ready;
    } mbs_eng_s;

    typedef struct packed {
        logic in_frame;
        logic reply_ok;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_sof;
        logic rx_err;
        logic tx_ready;
    } mbs_chan_s;

endpackage

// ==== mbs_char_port.sv ====
`timescale 1ns/1ns
module mbs_char_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire mbs_pkg::mbs_div_t div,
    input wire logic [1:0] parity,
    input wire logic two_stop,
    input wire logic rxd,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic txd,
    output logic de,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_perr,
    output logic rx_ferr,
    output logic rx_first
);
    import mbs_pkg::*;

    mbs_eng_s s_reg, s_next;
    logic [3:0] char_bits;
    logic [IDLE_W-1:0] idle_lim;
    logic par_on;

    assign par_on = (parity != PAR_NONE);
    assign char_bits = CHAR_BITS_BASE + {3'h0, par_on} + {3'h0, two_stop};
    assign idle_lim = IDLE_W'(int'(char_bits) * OVS * GAP_HALF_CHARS / 2);

    // ****************************************************************
    // oversample tick, receiver, transmitter
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.rx_valid = 1'b0;
        s_next.tick = 1'b0;
        if (s_reg.div_cnt >= div - 1'b1) begin
            s_next.div_cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 1'b1;
        end
        if (s_reg.tick) begin
            if (s_reg.st_rx == ST_IDLE && rxd) begin
                if (s_reg.idle_cnt >= idle_lim) begin
                    s_next.gap_seen = 1'b1;
                end else begin
                    s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
                end
            end
            s_next.rx_tick = s_reg.rx_tick + 1'b1;
            case (s_reg.st_rx)
                ST_IDLE: begin
                    if (!rxd) begin
                        s_next.st_rx = ST_START;
                        s_next.rx_tick = '0;
                        s_next.idle_cnt = '0;
                    end
                end
                ST_START: begin
                    if (s_reg.rx_tick == 3'(OVS_HALF - 1)) begin
                        s_next.rx_tick = '0;
                        s_next.rx_bit = '0;
                        s_next.st_rx = rxd ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (s_reg.rx_tick == 3'(OVS - 1)) begin
                        s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
                        s_next.rx_bit = s_reg.rx_bit + 1'b1;
                        if (s_reg.rx_bit == 3'h7) begin
                            s_next.st_rx = par_on ? ST_PAR : ST_STOP;
                        end
                    end
                end
                ST_PAR: begin
                    if (s_reg.rx_tick == 3'(OVS - 1)) begin
                        s_next.rx_par = rxd;
                        s_next.st_rx = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (s_reg.rx_tick == 3'(OVS - 1)) begin
                        s_next.rx_data = s_reg.rx_sh;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_ferr = !rxd;
                        s_next.rx_perr = (parity == PAR_EVEN && s_reg.rx_par != ^s_reg.rx_sh)
                            || (parity == PAR_ODD && s_reg.rx_par != ~^s_reg.rx_sh);
                        s_next.rx_first = s_reg.gap_seen;
                        s_next.gap_seen = 1'b0;
                        s_next.idle_cnt = '0;
                        s_next.st_rx = ST_IDLE;
                    end
                end
                default: s_next.st_rx = ST_IDLE;
            endcase
        end
        if (s_reg.st_tx == ST_IDLE) begin
            if (tx_valid && s_reg.tx_ready) begin
                s_next.st_tx = ST_START;
                s_next.tx_sh = tx_data;
                s_next.tx_par = (parity == PAR_ODD) ? ~^tx_data : ^tx_data;
                s_next.txd = 1'b0;
                s_next.de = 1'b1;
                s_next.tx_tick = '0;
                s_next.tx_ready = 1'b0;
            end
        end else if (s_reg.tick) begin
            s_next.tx_tick = s_reg.tx_tick + 1'b1;
            if (s_reg.tx_tick == 3'(OVS - 1)) begin
                case (s_reg.st_tx)
                    ST_START: begin
                        s_next.st_tx = ST_DATA;
                        s_next.txd = s_reg.tx_sh[0];
                        s_next.tx_bit = '0;
                    end
                    ST_DATA: begin
                        s_next.tx_sh = s_reg.tx_sh >> 1;
                        s_next.tx_bit = s_reg.tx_bit + 1'b1;
                        s_next.txd = s_reg.tx_sh[1];
                        if (s_reg.tx_bit == 3'h7) begin
                            s_next.st_tx = par_on ? ST_PAR : ST_STOP;
                            s_next.txd = par_on ? s_reg.tx_par : 1'b1;
                            s_next.tx_bit = '0;
                        end
                    end
                    ST_PAR: begin
                        s_next.st_tx = ST_STOP;
                        s_next.txd = 1'b1;
                    end
                    ST_STOP: begin
                        if (two_stop && s_reg.tx_bit == 3'h0) begin
                            s_next.tx_bit = 3'h1;
                        end else begin
                            s_next.st_tx = ST_IDLE;
                            s_next.de = 1'b0;
                            s_next.tx_ready = 1'b1;
                        end
                    end
                    default: s_next.st_tx = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st_rx: ST_IDLE, st_tx: ST_IDLE, txd: 1'b1, tx_ready: 1'b1,
                gap_seen: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_ready = s_reg.tx_ready;
    assign txd = s_reg.txd;
    assign de = s_reg.de;
    assign rx_data = s_reg.rx_data;
    assign rx_valid = s_reg.rx_valid;
    assign rx_perr = s_reg.rx_perr;
    assign rx_ferr = s_reg.rx_ferr;
    assign rx_first = s_reg.rx_first;

    // ****************************************************************
    // checks
    // ****************************************************************
    tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tick |-> $past(s_reg.div_cnt) >= $past(div) - 1'b1)
        else $error("oversample tick out of period");
    driver_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.st_tx == ST_IDLE |-> !s_reg.de && s_reg.txd)
        else $error("driver enabled while idle");
    start_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.st_tx == ST_START |-> !s_reg.txd && s_reg.de)
        else $error("start bit not low");
    parity_gen_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.st_tx == ST_PAR |-> s_reg.txd == s_reg.tx_par)
        else $error("parity bit wrong");
    no_par_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.rx_valid && parity == PAR_NONE |-> !s_reg.rx_perr)
        else $error("parity error without parity");
    start_confirm_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tick && s_reg.st_rx == ST_START && s_reg.rx_tick == 3'(OVS_HALF - 1) && rxd
        |=> s_reg.st_rx == ST_IDLE)
        else $error("false start accepted");
    stop_check_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tick && s_reg.st_rx == ST_STOP && s_reg.rx_tick == 3'(OVS - 1)
        |=> s_reg.rx_valid && s_reg.rx_ferr == !$past(rxd))
        else $error("stop bit check wrong");
    idle_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.tick && s_reg.st_rx == ST_IDLE && !rxd |=> s_reg.idle_cnt == '0)
        else $error("idle count not restarted");
    first_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.rx_valid |-> s_reg.rx_first == $past(s_reg.gap_seen) && !s_reg.gap_seen)
        else $error("address flag not from gap");

endmodule // mbs_char_port

// ==== mbs_serial_port.sv ====
`timescale 1ns/1ns
// Behaviour
// - A received byte that follows more than 3.5 character times of silence opens a frame.
// - The point-to-point port is fixed at 2400 baud, 8N1, node address 1.
// - A default multipoint character is eight data bits, no parity and one stop bit.
// - The multipoint bit rate is selectable among eight rates from 1200 to 115200 baud.
// - After reset the multipoint port runs at 38400 baud until reconfigured.
// - The multipoint node address is 1 to 255, defaults to 1, and only matching frames pass.
// - Parity is none, even or odd; the sender makes the bit and the receiver checks it.
// - A parity mismatch is flagged and never corrected.
// - The line driver is enabled only while the slave sends and released afterwards.
// - Broadcasts get no answer and a query gets at most one response.
// - Every character has one start bit, eight data bits, optional parity, one or two stops.
module mbs_serial_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic p2p_rxd,
    output logic p2p_txd,
    input wire logic mp_rxd,
    output logic mp_txd,
    output logic mp_de,
    input wire logic mp_cfg_load,
    input wire logic [2:0] mp_baud_sel,
    input wire logic [7:0] mp_node_addr,
    input wire logic [1:0] mp_parity,
    input wire logic mp_two_stop,
    output logic [7:0] p2p_rx_data,
    output logic p2p_rx_valid,
    output logic p2p_rx_sof,
    output logic p2p_rx_err,
    input wire logic [7:0] p2p_tx_data,
    input wire logic p2p_tx_valid,
    input wire logic p2p_tx_last,
    output logic p2p_tx_ready,
    output logic [7:0] mp_rx_data,
    output logic mp_rx_valid,
    output logic mp_rx_sof,
    output logic mp_rx_err,
    input wire logic [7:0] mp_tx_data,
    input wire logic mp_tx_valid,
    input wire logic mp_tx_last,
    output logic mp_tx_ready
);
    import mbs_pkg::*;

    // ****************************************************************
    // multipoint configuration
    // ****************************************************************
    logic [2:0] cfg_baud_reg;
    logic [7:0] cfg_addr_reg;
    logic [1:0] cfg_par_reg;
    logic cfg_stop2_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_baud_reg <= BAUD_SEL_RST;
            cfg_addr_reg <= NODE_ADDR_RST;
            cfg_par_reg <= PAR_NONE;
            cfg_stop2_reg <= 1'b0;
        end else if (mp_cfg_load) begin
            cfg_baud_reg <= mp_baud_sel;
            if (mp_node_addr != BCAST_ADDR) begin
                cfg_addr_reg <= mp_node_addr;
            end
            cfg_par_reg <= (mp_parity == 2'h3) ? PAR_NONE : mp_parity;
            cfg_stop2_reg <= mp_two_stop;
        end
    end

    // ****************************************************************
    // per-port wiring; port 0 is point-to-point, port 1 multipoint
    // ****************************************************************
    mbs_div_t ch_div [2];
    logic [1:0] ch_par [2];
    logic [7:0] ch_addr [2];
    logic [7:0] ch_tx_data [2];
    logic [7:0] e_rx_data [2];
    logic [1:0] ch_stop2, ch_rxd, ch_txd, ch_de, ch_tx_valid, ch_tx_last;
    logic [1:0] e_tx_valid, e_tx_ready, e_rx_valid, e_perr, e_ferr, e_first;
    mbs_chan_s c_reg [2];

    assign ch_div[0] = baud_div(BAUD_SEL_2400);
    assign ch_par[0] = PAR_NONE;
    assign ch_stop2[0] = 1'b0;
    assign ch_addr[0] = P2P_NODE_ADDR;
    assign ch_div[1] = baud_div(cfg_baud_reg);
    assign ch_par[1] = cfg_par_reg;
    assign ch_stop2[1] = cfg_stop2_reg;
    assign ch_addr[1] = cfg_addr_reg;
    assign ch_rxd = {mp_rxd, p2p_rxd};
    assign ch_tx_data[0] = p2p_tx_data;
    assign ch_tx_data[1] = mp_tx_data;
    assign ch_tx_valid = {mp_tx_valid, p2p_tx_valid};
    assign ch_tx_last = {mp_tx_last, p2p_tx_last};

    // ****************************************************************
    // character engine and frame filter per port
    // ****************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_ch
        mbs_chan_s c_next;

        assign e_tx_valid[i] = ch_tx_valid[i] && c_reg[i].tx_ready;

        mbs_char_port u_eng (
            .clk(clk),
            .rst_n(rst_n),
            .div(ch_div[i]),
            .parity(ch_par[i]),
            .two_stop(ch_stop2[i]),
            .rxd(ch_rxd[i]),
            .tx_data(ch_tx_data[i]),
            .tx_valid(e_tx_valid[i]),
            .tx_ready(e_tx_ready[i]),
            .txd(ch_txd[i]),
            .de(ch_de[i]),
            .rx_data(e_rx_data[i]),
            .rx_valid(e_rx_valid[i]),
            .rx_perr(e_perr[i]),
            .rx_ferr(e_ferr[i]),
            .rx_first(e_first[i])
        );

        always_comb begin
            c_next = c_reg[i];
            c_next.rx_valid = 1'b0;
            if (e_rx_valid[i]) begin
                c_next.rx_data = e_rx_data[i];
                c_next.rx_err = e_perr[i] || e_ferr[i];
                if (e_first[i]) begin
                    // address byte: own address, never broadcast, clean character
                    c_next.in_frame = (e_rx_data[i] == ch_addr[i])
                        && (e_rx_data[i] != BCAST_ADDR) && !e_perr[i] && !e_ferr[i];
                    c_next.reply_ok = c_next.in_frame;
                    c_next.rx_valid = c_next.in_frame;
                    c_next.rx_sof = 1'b1;
                end else begin
                    c_next.rx_valid = c_reg[i].in_frame;
                    c_next.rx_sof = 1'b0;
                end
            end
            if (e_tx_valid[i] && ch_tx_last[i]) begin
                c_next.reply_ok = 1'b0;
                c_next.in_frame = 1'b0;
            end
            c_next.tx_ready = c_next.reply_ok && e_tx_ready[i] && !e_tx_valid[i];
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                c_reg[i] <= '0;
            end else begin
                c_reg[i] <= c_next;
            end
        end

        sof_match_a: assert property (@(posedge clk) disable iff (!rst_n)
            c_reg[i].rx_valid && c_reg[i].rx_sof
            |-> c_reg[i].rx_data == $past(ch_addr[i]) && c_reg[i].rx_data != BCAST_ADDR)
            else $error("frame passed with foreign address");
        reply_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
            e_tx_valid[i] |-> c_reg[i].reply_ok && e_tx_ready[i])
            else $error("send without query");
        one_reply_a: assert property (@(posedge clk) disable iff (!rst_n)
            e_tx_valid[i] && ch_tx_last[i] |=> !c_reg[i].reply_ok && !c_reg[i].tx_ready)
            else $error("second response allowed");
    end

    assign p2p_txd = ch_txd[0];
    assign mp_txd = ch_txd[1];
    assign mp_de = ch_de[1];
    assign p2p_rx_data = c_reg[0].rx_data;
    assign p2p_rx_valid = c_reg[0].rx_valid;
    assign p2p_rx_sof = c_reg[0].rx_sof;
    assign p2p_rx_err = c_reg[0].rx_err;
    assign p2p_tx_ready = c_reg[0].tx_ready;
    assign mp_rx_data = c_reg[1].rx_data;
    assign mp_rx_valid = c_reg[1].rx_valid;
    assign mp_rx_sof = c_reg[1].rx_sof;
    assign mp_rx_err = c_reg[1].rx_err;
    assign mp_tx_ready = c_reg[1].tx_ready;

    // ****************************************************************
    // checks
    // ****************************************************************
    cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(mp_cfg_load) |-> $stable(cfg_baud_reg) && $stable(cfg_addr_reg))
        else $error("config changed without load");
    addr_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_addr_reg != BCAST_ADDR)
        else $error("node address zero");
    p2p_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        ch_div[0] == baud_div(BAUD_SEL_2400) && ch_par[0] == PAR_NONE && !ch_stop2[0])
        else $error("point-to-point format changed");

endmodule // mbs_serial_port

// ==== mbs_master_model.sv ====
`timescale 1ns/1ns
module mbs_master_model (
    input wire logic clk,
    output logic rxd,
    input wire logic txd,
    input wire logic de
);
    initial rxd = 1'b1;
    // ****************************************************************
    // query characters: start, lsb first, optional parity, stop
    // ****************************************************************
    task automatic send(input logic [7:0] d, input logic [1:0] par, input int bc,
                        input logic [1:0] bad);
        logic [10:0] fr;
        fr = {~bad[1], (par == 2'h0) ? 1'b1 : (^d ^ (par == 2'h2) ^ bad[0]), d, 1'b0};
        for (int i = 0; i < ((par == 2'h0) ? 10 : 11); i++) begin
            rxd <= fr[i];
            repeat (bc) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask
    // ****************************************************************
    // reply characters sampled at bit centres
    // ****************************************************************
    task automatic recv(input int bc, output logic [7:0] d, output logic p, output logic de_ok);
        int w;
        w = 0;
        de_ok = 1'b1;
        while (txd !== 1'b0 && w < 20000) begin
            @(posedge clk);
            w++;
        end
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bc) @(posedge clk);
            de_ok &= (de === 1'b1);
            if (i < 8) d[i] = txd;
            else p = txd;
        end
    endtask
endmodule // mbs_master_model

// ==== test_modbus_rtu_serial_port.sv ====
`timescale 1ns/1ns
module test_modbus_rtu_serial_port;
    import mbs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mp_cfg_load = 1'b0, mp_tx_valid = 1'b0, mp_tx_last = 1'b0;
    logic [2:0] mp_baud_sel = 3'h5;
    logic [7:0] mp_node_addr = 8'h01, mp_tx_data = 8'h00, p2p_rx_data, mp_rx_data, addr, d, rd;
    logic [1:0] mp_parity = 2'h0;
    logic p2p_rxd, p2p_txd, mp_rxd, mp_txd, mp_de, p2p_rx_valid, p2p_rx_sof, p2p_rx_err;
    logic p2p_tx_ready, mp_rx_valid, mp_rx_sof, mp_rx_err, mp_tx_ready, rp, de_ok;
    logic [31:0] rs = 32'hB49F;
    logic [9:0] mq[$], pq[$];
    int miscompares = 0, samples_checked = 0, bc;
    always #50 clk = ~clk;
    mbs_serial_port dut (.clk(clk), .rst_n(rst_n), .p2p_rxd(p2p_rxd), .p2p_txd(p2p_txd),
        .mp_rxd(mp_rxd), .mp_txd(mp_txd), .mp_de(mp_de), .mp_cfg_load(mp_cfg_load),
        .mp_baud_sel(mp_baud_sel), .mp_node_addr(mp_node_addr), .mp_parity(mp_parity),
        .mp_two_stop(1'b0), .p2p_rx_data(p2p_rx_data), .p2p_rx_valid(p2p_rx_valid),
        .p2p_rx_sof(p2p_rx_sof), .p2p_rx_err(p2p_rx_err), .p2p_tx_data(8'h00),
        .p2p_tx_valid(1'b0), .p2p_tx_last(1'b0), .p2p_tx_ready(p2p_tx_ready),
        .mp_rx_data(mp_rx_data), .mp_rx_valid(mp_rx_valid), .mp_rx_sof(mp_rx_sof),
        .mp_rx_err(mp_rx_err), .mp_tx_data(mp_tx_data), .mp_tx_valid(mp_tx_valid),
        .mp_tx_last(mp_tx_last), .mp_tx_ready(mp_tx_ready));
    mbs_master_model mp_m (.clk(clk), .rxd(mp_rxd), .txd(mp_txd), .de(mp_de));
    mbs_master_model p2p_m (.clk(clk), .rxd(p2p_rxd), .txd(p2p_txd), .de(1'b1));
    always @(posedge clk) begin
        if (mp_rx_valid === 1'b1) mq.push_back({mp_rx_sof, mp_rx_err, mp_rx_data});
        if (p2p_rx_valid === 1'b1) pq.push_back({p2p_rx_sof, p2p_rx_err, p2p_rx_data});
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic int bitc(input int b);
        return 8 * ((10_000_000 + b * 4) / (b * 8));
    endfunction
    function automatic logic [7:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs[7:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic mp_q(input logic [7:0] b, input logic [1:0] bad, input int gap);
        repeat (gap) @(posedge clk);
        mp_m.send(b, mp_parity, bc, bad);
        repeat (10) @(posedge clk);
    endtask
    task automatic reply(input logic [7:0] b);
        mp_tx_data <= b;
        mp_tx_valid <= 1'b1;
        mp_tx_last <= 1'b1;
        for (int w = 0; w < 99; w++) begin
            @(posedge clk);
            if (mp_tx_ready === 1'b1) break;
        end
        mp_tx_valid <= 1'b0;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({mp_de, mp_txd, mp_tx_ready}, 3'b010);
        fork
            begin
                p2p_m.send(8'h01, 2'h0, bitc(2400), 2'h0);
                repeat (10) @(posedge clk);
                check(pq.size() ? pq.pop_front() : 10'h3FF, 10'h201);
            end
            begin
                bc = bitc(38400);
                mp_q(8'h01, 2'h0, 0);
                check(mq.size() ? mq.pop_front() : 10'h3FF, 10'h201);
                mp_q(8'h5A, 2'h0, 0);
                check(mq.size() ? mq.pop_front() : 10'h3FF, 10'h05A);
                bc = bitc(115200);
                for (int m = 1; m < 3; m++) begin
                    addr = rnd() | 8'h01;
                    d = rnd();
                    @(posedge clk);
                    {mp_cfg_load, mp_baud_sel, mp_node_addr, mp_parity} <= {4'hF, addr, 2'(m)};
                    @(posedge clk);
                    mp_cfg_load <= 1'b0;
                    mp_q(addr, 2'h0, 4000);
                    check(mq.size() ? mq.pop_front() : 10'h3FF, {2'b10, addr});
                    mp_q(d, 2'h1, 0);
                    check(mq.size() ? mq.pop_front() : 10'h3FF, {2'b01, d});
                    mp_q(d, 2'h0, 0);
                    check(mq.size() ? mq.pop_front() : 10'h3FF, {2'b00, d});
                    mp_q(d, 2'h0, 3200);
                    check(mq.size() ? mq.pop_front() : 10'h3FF, {2'b00, d});
                    mp_q(d, 2'h2, 0);
                    check(mq.size() ? mq.pop_front() : 10'h3FF, {2'b01, d});
                    check(mp_tx_ready, 1'b1);
                    fork
                        reply(~d);
                        mp_m.recv(bc, rd, rp, de_ok);
                    join
                    check({rd, rp, de_ok}, {~d, ^d ^ (m == 2), 1'b1});
                    // wait out the rest of the parity bit and the stop bit
                    repeat (200) @(posedge clk);
                    check({mp_de, mp_tx_ready}, 2'b00);
                    mp_q(addr ^ 8'h02, 2'h0, 4000);
                    mq.delete();
                    mp_q(d, 2'h0, 0);
                    mp_q(BCAST_ADDR, 2'h0, 4000);
                    mp_q(d, 2'h0, 0);
                    check({mq.size(), mp_tx_ready}, 33'h0);
                end
            end
        join
        tally_and_finish();
    end
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // test_modbus_rtu_serial_port
